// ==== common/pfpt_defines.svh ====
// Constants of the fault, power-good and telemetry command block.
`ifndef PFPT_DEFINES_SVH
`define PFPT_DEFINES_SVH

// Clock period of the system domain in nanoseconds.
`define PFPT_CLK_NS 4
// Telemetry period and the derived cycle count.
`define PFPT_TELEM_US 200
`define PFPT_TELEM_CYC ((`PFPT_TELEM_US * 1000) / `PFPT_CLK_NS)
`define PFPT_SAMPLES 16
// Restart delay after a shutdown with continuous restart selected.
`define PFPT_RESTART_NS 10000
`define PFPT_RESTART_CYC ((`PFPT_RESTART_NS + `PFPT_CLK_NS - 1) / `PFPT_CLK_NS)
`define PFPT_SW_CYCLES 4

// Command codes of the link.
`define PFPT_CMD_CLEAR 8'h03
`define PFPT_CMD_STORE 8'h11
`define PFPT_CMD_VIN_ON 8'h35
`define PFPT_CMD_VIN_OFF 8'h36
`define PFPT_CMD_IGAIN 8'h38
`define PFPT_CMD_IOFFS 8'h39
`define PFPT_CMD_OV_RESP 8'h41
`define PFPT_CMD_UV_RESP 8'h45
`define PFPT_CMD_PG_ON 8'h5e
`define PFPT_CMD_PG_OFF 8'h5f
`define PFPT_CMD_STAT_BYTE 8'h78
`define PFPT_CMD_STAT_CML 8'h7e
`define PFPT_CMD_READ_VIN 8'h88
`define PFPT_CMD_READ_VOUT 8'h8b
`define PFPT_CMD_MEASURED_OUTPUT_CURRENT 8'h8c
`define PFPT_CMD_VOFFS 8'hd4
`define PFPT_CMD_VGAIN 8'hd5

// Fixed exponents of the linear words.
`define PFPT_EXP_VIN_TH 5'h1e
`define PFPT_EXP_IGAIN 5'h11
`define PFPT_EXP_IOFFS 5'h1c
`define PFPT_EXP_IOUT 5'h1c
`define PFPT_EXP_VGAIN 5'h18
`define PFPT_EXP_VIN 5'h1b

// Threshold mantissas in quarter volts.
`define PFPT_VIN_ON_MIN 7'h0b
`define PFPT_VIN_OFF_MIN 7'h0a
`define PFPT_VIN_MAX 7'h38

// Field positions.
`define PFPT_RESP_CODE 7:6
`define PFPT_RESP_RESTART 5:3
`define PFPT_CML_BIT 1
`define PFPT_CML_INV_BIT 7
`define PFPT_CML_CMD_BIT 6

// Reset values, offset limits and the current gain shift.
`define PFPT_OV_RESP_RST 8'h80
`define PFPT_UV_RESP_RST 8'h80
`define PFPT_VIN_ON_RST 16'hf00c
`define PFPT_VIN_OFF_RST 16'hf00a
`define PFPT_PG_ON_RST 16'h046a
`define PFPT_PG_OFF_RST 16'h0452
`define PFPT_IGAIN_RST 16'h8800
`define PFPT_IOFFS_RST 16'he000
`define PFPT_VOFFS_RST 16'h0000
`define PFPT_VGAIN_RST 16'hc000
`define PFPT_VOFFS_MIN (-32'sd128)
`define PFPT_VOFFS_MAX 32'sd127
`define PFPT_IGAIN_SHIFT 11

`endif

// ==== common/pfpt_pkg.sv ====
// Types shared by the fault, power-good and telemetry command block.
package pfpt_pkg;

   // Fault response sequence, Gray coded along run, count, off.
   typedef enum logic [1:0]
   {
      PFPT_RUN = 2'b00,
      PFPT_COUNT = 2'b01,
      PFPT_OFF = 2'b11,
      PFPT_HOLD = 2'b10
   } pfpt_resp_st_t;

   typedef struct packed
   {
      pfpt_resp_st_t st;
      logic [11:0] cnt;
   } pfpt_resp_ctx_t;

   // One command from the link, held stable while in flight.
   typedef struct packed
   {
      logic write;
      logic [7:0] cmd;
      logic [15:0] wdata;
   } pfpt_req_t;

   // One set of converter samples.
   typedef struct packed
   {
      logic [15:0] iout;
      logic [15:0] vout;
      logic [15:0] vin;
   } pfpt_samp_t;

   // Link-side state.
   typedef struct packed
   {
      logic req_tgl;
      logic busy;
      logic done;
      logic ack_s1;
      logic ack_s2;
      logic ack_seen;
      pfpt_req_t req;
      logic [15:0] rdata;
   } pfpt_lk_t;

   // System-side state.
   typedef struct packed
   {
      logic [3:0] flt_s1;
      logic [3:0] flt_s2;
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic ack_tgl;
      logic [15:0] rdata;
      logic [7:0] ov_resp;
      logic [7:0] uv_resp;
      logic [15:0] vin_on;
      logic [15:0] vin_off;
      logic [15:0] pg_on;
      logic [15:0] pg_off;
      logic [15:0] igain;
      logic [15:0] ioffs;
      logic [15:0] voffs;
      logic [15:0] vgain;
      pfpt_resp_ctx_t [1:0] resp;
      logic cml_inv;
      logic cml_cmd;
      logic rej;
      logic store;
      logic pg_good;
      logic conv_en;
      logic alert_oe_b;
      logic [19:0] per_cnt;
      logic acq;
      logic [3:0] nsamp;
      logic [19:0] acc_i;
      logic [19:0] acc_v;
      logic [19:0] acc_n;
      logic [15:0] meas_i;
      logic [15:0] meas_v;
      logic [15:0] meas_n;
   } pfpt_sys_t;

endpackage

// ==== hdl/pfpt_top.sv ====
// Command logic for fault response, power-good and averaged telemetry.
`timescale 1ns/1ps
`default_nettype none
`include "pfpt_defines.svh"

module pfpt_top
#(
   parameter int TELEM_CYC = `PFPT_TELEM_CYC
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic link_clk,
   input wire logic lk_req,
   input wire pfpt_pkg::pfpt_req_t lk_cmd,
   output logic lk_busy,
   output logic lk_done,
   output logic [15:0] lk_rdata,
   input wire logic [3:0] fault_pins,
   input wire logic sw_tick,
   input wire logic adc_valid,
   input wire pfpt_pkg::pfpt_samp_t adc_samp,
   input wire logic [15:0] vout_nominal,
   output logic conv_enable,
   output logic output_good_flag_o,
   output logic output_good_flag_oe_b,
   output logic smbalert_o,
   output logic smbalert_oe_b,
   output logic nvm_store
);

   pfpt_pkg::pfpt_lk_t lk;
   pfpt_pkg::pfpt_lk_t next_lk;
   pfpt_pkg::pfpt_sys_t s;
   pfpt_pkg::pfpt_sys_t next_s;

   // =========================================================
   // Helper functions
   // =========================================================

   // Sign-extends an eleven-bit mantissa.
   function automatic logic signed [31:0] sext11(input logic [10:0] m);
      return 32'(signed'({{21{m[10]}}, m}));
   endfunction

   // Sign-extends a sixteen-bit word.
   function automatic logic signed [31:0] sext16(input logic [15:0] w);
      return 32'(signed'({{16{w[15]}}, w}));
   endfunction

   // Snaps a threshold mantissa onto the half-volt grid above a floor.
   function automatic logic [6:0] quant_vin(input logic [15:0] w, input logic [6:0] lo);
      logic [6:0] m;
      logic [6:0] q;
      m = (w[10:7] != 4'h0) ? 7'h7f : w[6:0];
      if (m <= lo)
      begin
         q = lo;
      end
      else if (m >= `PFPT_VIN_MAX)
      begin
         q = `PFPT_VIN_MAX;
      end
      else
      begin
         q = m[0] ? 7'(m + 7'h01) : m;
      end
      return q;
   endfunction

   // Clamps a signed value into an unsigned range.
   function automatic logic [15:0] clampu(input logic signed [31:0] v, input logic [15:0] hi);
      logic [15:0] r;
      if (v < 0)
      begin
         r = 16'h0000;
      end
      // The ceiling is compared zero-extended, so a full-scale ceiling never reads as minus one.
      else if (v > signed'({16'h0000, hi}))
      begin
         r = hi;
      end
      else
      begin
         r = v[15:0];
      end
      return r;
   endfunction

   // One step of a fault response sequence.
   function automatic pfpt_pkg::pfpt_resp_ctx_t resp_step(
      input pfpt_pkg::pfpt_resp_ctx_t c,
      input logic [7:0] code,
      input logic flt,
      input logic tick,
      input logic clr);
      pfpt_pkg::pfpt_resp_ctx_t r;
      r = c;
      case (c.st)
         pfpt_pkg::PFPT_RUN:
         begin
            r.cnt = 12'h000;
            if (flt && code[`PFPT_RESP_CODE] == 2'b01)
            begin
               r.st = pfpt_pkg::PFPT_COUNT;
            end
            else if (flt && code[`PFPT_RESP_CODE] == 2'b10)
            begin
               r.st = pfpt_pkg::PFPT_OFF;
            end
            else if (flt && code[`PFPT_RESP_CODE] == 2'b11)
            begin
               r.st = pfpt_pkg::PFPT_HOLD;
            end
         end
         pfpt_pkg::PFPT_COUNT:
         begin
            if (!flt)
            begin
               r.st = pfpt_pkg::PFPT_RUN;
            end
            else if (tick && c.cnt == 12'(`PFPT_SW_CYCLES - 1))
            begin
               r.st = pfpt_pkg::PFPT_OFF;
               r.cnt = 12'h000;
            end
            else if (tick)
            begin
               r.cnt = 12'(c.cnt + 12'h001);
            end
         end
         pfpt_pkg::PFPT_OFF:
         begin
            if (clr)
            begin
               r.st = pfpt_pkg::PFPT_RUN;
            end
            else if (code[`PFPT_RESP_RESTART] == 3'b111)
            begin
               if (c.cnt == 12'(`PFPT_RESTART_CYC - 1))
               begin
                  r.st = pfpt_pkg::PFPT_RUN;
               end
               r.cnt = 12'(c.cnt + 12'h001);
            end
         end
         pfpt_pkg::PFPT_HOLD:
         begin
            if (!flt)
            begin
               r.st = pfpt_pkg::PFPT_RUN;
            end
         end
         default:
         begin
            r.st = pfpt_pkg::PFPT_RUN;
         end
      endcase
      return r;
   endfunction

   // =========================================================
   // Link domain
   // =========================================================

   // Takes one command at a time and waits for the returned toggle.
   always_comb
   begin
      next_lk = lk;
      next_lk.done = 1'b0;
      next_lk.ack_s1 = s.ack_tgl;
      next_lk.ack_s2 = lk.ack_s1;
      if (!lk.busy && lk_req)
      begin
         next_lk.req = lk_cmd;
         next_lk.req_tgl = ~lk.req_tgl;
         next_lk.busy = 1'b1;
      end
      else if (lk.busy && lk.ack_s2 != lk.ack_seen)
      begin
         // Read data stands still on the system side until the next request.
         next_lk.ack_seen = lk.ack_s2;
         next_lk.busy = 1'b0;
         next_lk.done = 1'b1;
         next_lk.rdata = s.rdata;
      end
   end

   always_ff @(posedge link_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lk <= '0;
      end
      else
      begin
         lk <= next_lk;
      end
   end

   // =========================================================
   // System domain
   // =========================================================

   // Command decode, fault responses, power-good and telemetry.
   always_comb
   begin
      logic take;
      logic clr;
      logic unsup;
      logic [6:0] q;
      logic [3:0] flt;
      logic signed [31:0] t;
      logic [16:0] hi_on;
      logic [16:0] hi_off;
      logic [16:0] v;
      logic [19:0] ai;
      logic [19:0] av;
      logic [19:0] an;
      logic [15:0] cl;
      next_s = s;
      take = 1'b0;
      clr = 1'b0;
      unsup = 1'b0;
      q = 7'h00;
      flt = 4'h0;
      t = 32'sh0000_0000;
      hi_on = 17'h0_0000;
      hi_off = 17'h0_0000;
      v = 17'h0_0000;
      ai = 20'h0_0000;
      av = 20'h0_0000;
      an = 20'h0_0000;
      cl = 16'h0000;
      next_s.rej = 1'b0;
      next_s.store = 1'b0;
      next_s.flt_s1 = fault_pins;
      next_s.flt_s2 = s.flt_s1;
      next_s.req_s1 = lk.req_tgl;
      next_s.req_s2 = s.req_s1;
      flt = s.flt_s2;
      if (s.req_s2 != s.req_seen)
      begin
         take = 1'b1;
         next_s.req_seen = s.req_s2;
         next_s.ack_tgl = ~s.ack_tgl;
      end
      if (take && lk.req.write)
      begin
         case (lk.req.cmd)
            `PFPT_CMD_CLEAR: clr = 1'b1;
            `PFPT_CMD_STORE:
            begin
               next_s.store = 1'b1;
            end
            `PFPT_CMD_OV_RESP: next_s.ov_resp = lk.req.wdata[7:0];
            `PFPT_CMD_UV_RESP: next_s.uv_resp = lk.req.wdata[7:0];
            `PFPT_CMD_VIN_ON:
            begin
               q = quant_vin(lk.req.wdata, `PFPT_VIN_ON_MIN);
               if (q < s.vin_off[6:0])
               begin
                  next_s.rej = 1'b1;
               end
               else
               begin
                  next_s.vin_on = {`PFPT_EXP_VIN_TH, 4'h0, q};
               end
            end
            `PFPT_CMD_VIN_OFF:
            begin
               q = quant_vin(lk.req.wdata, `PFPT_VIN_OFF_MIN);
               if (q > s.vin_on[6:0])
               begin
                  next_s.rej = 1'b1;
               end
               else
               begin
                  next_s.vin_off = {`PFPT_EXP_VIN_TH, 4'h0, q};
               end
            end
            `PFPT_CMD_PG_ON: next_s.pg_on = {1'b0, lk.req.wdata[14:0]};
            `PFPT_CMD_PG_OFF: next_s.pg_off = {1'b0, lk.req.wdata[14:0]};
            `PFPT_CMD_IGAIN: next_s.igain = {`PFPT_EXP_IGAIN, lk.req.wdata[10:0]};
            `PFPT_CMD_IOFFS: next_s.ioffs = {`PFPT_EXP_IOFFS, lk.req.wdata[10:0]};
            `PFPT_CMD_VGAIN: next_s.vgain = {`PFPT_EXP_VGAIN, lk.req.wdata[10:0]};
            `PFPT_CMD_VOFFS:
            begin
               t = sext16(lk.req.wdata);
               if (t < `PFPT_VOFFS_MIN)
               begin
                  t = `PFPT_VOFFS_MIN;
               end
               else if (t > `PFPT_VOFFS_MAX)
               begin
                  t = `PFPT_VOFFS_MAX;
               end
               next_s.voffs = t[15:0];
            end
            default: unsup = 1'b1;
         endcase
      end
      else if (take)
      begin
         case (lk.req.cmd)
            `PFPT_CMD_OV_RESP: next_s.rdata = {8'h00, s.ov_resp};
            `PFPT_CMD_UV_RESP: next_s.rdata = {8'h00, s.uv_resp};
            `PFPT_CMD_VIN_ON: next_s.rdata = s.vin_on;
            `PFPT_CMD_VIN_OFF: next_s.rdata = s.vin_off;
            `PFPT_CMD_PG_ON: next_s.rdata = s.pg_on;
            `PFPT_CMD_PG_OFF: next_s.rdata = s.pg_off;
            `PFPT_CMD_IGAIN: next_s.rdata = s.igain;
            `PFPT_CMD_IOFFS: next_s.rdata = s.ioffs;
            `PFPT_CMD_VGAIN: next_s.rdata = s.vgain;
            `PFPT_CMD_VOFFS: next_s.rdata = s.voffs;
            `PFPT_CMD_MEASURED_OUTPUT_CURRENT: next_s.rdata = s.meas_i;
            `PFPT_CMD_READ_VOUT: next_s.rdata = s.meas_v;
            `PFPT_CMD_READ_VIN: next_s.rdata = s.meas_n;
            `PFPT_CMD_STAT_BYTE:
               next_s.rdata = 16'(s.cml_inv | s.cml_cmd) << `PFPT_CML_BIT;
            `PFPT_CMD_STAT_CML:
               next_s.rdata = 16'({s.cml_inv, s.cml_cmd, 6'h00});
            default:
            begin
               unsup = 1'b1;
               next_s.rdata = 16'h0000;
            end
         endcase
      end
      // Status bits and alert; a new event outranks a clear.
      next_s.cml_inv = (s.cml_inv & ~clr) | next_s.rej;
      next_s.cml_cmd = (s.cml_cmd & ~clr) | unsup;
      next_s.alert_oe_b = ~(next_s.cml_inv | next_s.cml_cmd);
      // Separate sequences for over and under voltage.
      next_s.resp[0] = resp_step(s.resp[0], s.ov_resp, flt[0], sw_tick, clr);
      next_s.resp[1] = resp_step(s.resp[1], s.uv_resp, flt[1], sw_tick, clr);
      next_s.conv_en = next_s.resp[0].st[1] == 1'b0 && next_s.resp[1].st[1] == 1'b0;
      // Upper limits mirror the lower ones about nominal.
      hi_on = 17'({vout_nominal, 1'b0} - {1'b0, s.pg_on});
      hi_off = 17'({vout_nominal, 1'b0} - {1'b0, s.pg_off});
      v = {1'b0, s.meas_v};
      // Faults and disable override the window.
      if (flt != 4'h0 || !s.conv_en)
      begin
         next_s.pg_good = 1'b0;
      end
      else if (!s.pg_good && v >= {1'b0, s.pg_on} && v <= hi_on)
      begin
         next_s.pg_good = 1'b1;
      end
      else if (s.pg_good && (v < {1'b0, s.pg_off} || v > hi_off))
      begin
         next_s.pg_good = 1'b0;
      end
      // Period timer opens a sixteen-sample window.
      if (s.per_cnt == 20'(TELEM_CYC - 1))
      begin
         next_s.per_cnt = 20'h0_0000;
         next_s.acq = 1'b1;
         next_s.nsamp = 4'h0;
         next_s.acc_i = 20'h0_0000;
         next_s.acc_v = 20'h0_0000;
         next_s.acc_n = 20'h0_0000;
      end
      else
      begin
         next_s.per_cnt = 20'(s.per_cnt + 20'h0_0001);
      end
      ai = 20'(s.acc_i + 20'(sext16(adc_samp.iout)));
      av = 20'(s.acc_v + 20'(sext16(adc_samp.vout)));
      an = 20'(s.acc_n + 20'(sext16(adc_samp.vin)));
      if (s.acq && adc_valid)
      begin
         next_s.acc_i = ai;
         next_s.acc_v = av;
         next_s.acc_n = an;
         next_s.nsamp = 4'(s.nsamp + 4'h1);
         if (s.nsamp == 4'(`PFPT_SAMPLES - 1))
         begin
            next_s.acq = 1'b0;
            t = (sext16(ai[19:4]) * sext11(s.igain[10:0])) >>> `PFPT_IGAIN_SHIFT;
            t = t + sext11(s.ioffs[10:0]);
            cl = clampu(t, 16'h03ff);
            next_s.meas_i = {`PFPT_EXP_IOUT, 1'b0, cl[9:0]};
            t = sext16(av[19:4]);
            t = t + ((t * sext11(s.vgain[10:0])) >>> 8) + sext16(s.voffs);
            next_s.meas_v = clampu(t, 16'hffff);
            t = sext16(an[19:4]);
            cl = clampu(t, 16'h03ff);
            next_s.meas_n = {`PFPT_EXP_VIN, 1'b0, cl[9:0]};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s <= '0;
         s.ov_resp <= `PFPT_OV_RESP_RST;
         s.uv_resp <= `PFPT_UV_RESP_RST;
         s.vin_on <= `PFPT_VIN_ON_RST;
         s.vin_off <= `PFPT_VIN_OFF_RST;
         s.pg_on <= `PFPT_PG_ON_RST;
         s.pg_off <= `PFPT_PG_OFF_RST;
         s.igain <= `PFPT_IGAIN_RST;
         s.ioffs <= `PFPT_IOFFS_RST;
         s.voffs <= `PFPT_VOFFS_RST;
         s.vgain <= `PFPT_VGAIN_RST;
         s.conv_en <= 1'b1;
         s.alert_oe_b <= 1'b1;
         s.meas_i <= {`PFPT_EXP_IOUT, 11'h000};
         s.meas_n <= {`PFPT_EXP_VIN, 11'h000};
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs; the open-drain data lines only ever pull low.
   assign lk_busy = lk.busy;
   assign lk_done = lk.done;
   assign lk_rdata = lk.rdata;
   assign conv_enable = s.conv_en;
   assign output_good_flag_o = 1'b0;
   assign output_good_flag_oe_b = s.pg_good;
   assign smbalert_o = 1'b0;
   assign smbalert_oe_b = s.alert_oe_b;
   assign nvm_store = s.store;

   // =========================================================
   // Checks
   // =========================================================

   sequence fault_seen_run(int i, logic [1:0] code);
      s.resp[i].st == pfpt_pkg::PFPT_RUN && s.flt_s2[i] && s.ov_resp[7:6] == code;
   endsequence

   a_ignore_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s.ov_resp[7:6] == 2'b00 && s.resp[0].st == pfpt_pkg::PFPT_RUN
      |=> s.resp[0].st == pfpt_pkg::PFPT_RUN || $changed(s.ov_resp))
      else $error("Code 00 left the run state.");
   a_delay_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fault_seen_run(0, 2'b01) |=> s.resp[0].st == pfpt_pkg::PFPT_COUNT && conv_enable)
      else $error("Code 01 did not start the cycle count.");
   a_immediate_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fault_seen_run(0, 2'b10) |=> !conv_enable)
      else $error("Code 10 did not shut down at once.");
   a_hold_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s.resp[0].st == pfpt_pkg::PFPT_HOLD && !s.flt_s2[0]
      |=> s.resp[0].st == pfpt_pkg::PFPT_RUN)
      else $error("Held output not released after fault cleared.");
   a_vin_order: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s.vin_on[6:0] >= s.vin_off[6:0] && s.vin_on[15:7] == {`PFPT_EXP_VIN_TH, 4'h0})
      else $error("Input thresholds crossed or badly formed.");
   a_reject_alert: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s.rej |-> s.cml_inv && !smbalert_oe_b && $stable(s.vin_on) && $stable(s.vin_off))
      else $error("Rejected write not flagged or not discarded.");
   a_pg_forced: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s.flt_s2 != 4'h0 |=> !output_good_flag_oe_b)
      else $error("Power-good not pulled low under a fault.");
   a_meas_whole: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $changed(s.meas_v) |-> $past(s.acq) && $past(s.nsamp) == 4'hf && !s.acq)
      else $error("Reading changed before a full average.");
   a_iout_form: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s.meas_i[15:10] == {`PFPT_EXP_IOUT, 1'b0} && s.meas_n[15:10] == {`PFPT_EXP_VIN, 1'b0})
      else $error("Reading word badly formed.");
   a_link_done: assert property (@(posedge link_clk) disable iff (!rst_b)
      lk_req && !lk_busy |=> lk_busy ##[2:16] lk_done)
      else $error("Link command not answered in time.");

endmodule
`default_nettype wire

// ==== bench/pfpt_host_model.sv ====
// Host model that issues one link command at a time.
`timescale 1ns/1ps
`default_nettype none
module pfpt_host_model
(
   input wire logic link_clk,
   input wire logic lk_busy,
   input wire logic lk_done,
   input wire logic [15:0] lk_rdata,
   output var logic lk_req,
   output var pfpt_pkg::pfpt_req_t lk_cmd
);
   // ====================
   // Transfer
   // Commands that never finish are counted here and charged by the bench.
   int timeouts = 0;
   initial
   begin
      lk_req = 1'b0;
      lk_cmd = '0;
   end
   // The word is inverted after the take, so a stale command never looks valid.
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
      output logic [15:0] q);
      int n;
      n = 0;
      @(negedge link_clk);
      lk_cmd = '{write: w, cmd: c, wdata: d};
      lk_req = 1'b1;
      @(negedge link_clk);
      lk_req = 1'b0;
      lk_cmd = ~lk_cmd;
      while (lk_done !== 1'b1 && n < 40)
      begin
         @(negedge link_clk);
         n++;
      end
      if (lk_done !== 1'b1)
      begin
         timeouts++;
      end
      q = lk_rdata;
   endtask
endmodule
`default_nettype wire

// ==== bench/pfpt_top_test.sv ====
// Self-checking bench of the fault, power-good and telemetry block.
`timescale 1ns/1ps
`default_nettype none
module pfpt_top_test;
   // ====================
   // Harness
   logic sys_clk, link_clk, rst_b, lk_req, lk_busy, lk_done, sw_tick, adc_valid;
   logic conv_enable, output_good_flag_oe_b, smbalert_oe_b, nvm_store;
   logic [3:0] fault_pins;
   logic [15:0] lk_rdata, vout_nominal, q, s;
   pfpt_pkg::pfpt_req_t lk_cmd;
   pfpt_pkg::pfpt_samp_t adc_samp;
   int errors = 0, checks = 0, stores = 0;
   pfpt_top #(.TELEM_CYC(64)) dut_u (.sys_clk, .rst_b, .link_clk, .lk_req, .lk_cmd,
      .lk_busy, .lk_done, .lk_rdata, .fault_pins, .sw_tick, .adc_valid, .adc_samp,
      .vout_nominal, .conv_enable, .output_good_flag_o(), .output_good_flag_oe_b,
      .smbalert_o(), .smbalert_oe_b, .nvm_store);
   pfpt_host_model host_u (.link_clk, .lk_busy, .lk_done, .lk_rdata, .lk_req, .lk_cmd);
   // The link clock is offset so its edges never line up with the system clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   // Samples arrive every other cycle; store pulses are counted.
   always @(negedge sys_clk) adc_valid <= ~adc_valid & rst_b;
   // Store pulses are looked at on the falling edge, where they have settled.
   always @(negedge sys_clk) if (nvm_store === 1'b1) stores++;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host_u.xfer(1'b1, c, d, q);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      host_u.xfer(1'b0, c, 16'h0000, q);
      chk(q, exp);
   endtask
   task automatic end_sim();
      errors += host_u.timeouts;
      $display("Mismatches %0d, comparisons %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // A hang is cut short well beyond the expected run time.
   initial
   begin
      #100000;
      errors++;
      end_sim();
   end
   initial
   begin
      {rst_b, sw_tick} = '0;
      fault_pins = 4'h0;
      vout_nominal = 16'h04cd;
      adc_samp = '{iout: 16'h0064, vout: 16'h04cd, vin: 16'h0100};
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge link_clk);
      rd(8'h5e, 16'h046a);
      rd(8'h5f, 16'h0452);
      wr(8'h36, 16'hf00b);
      rd(8'h36, 16'hf00c);
      wr(8'h36, 16'hf010);
      rd(8'h36, 16'hf00c);
      chk(smbalert_oe_b, 1'b0);
      rd(8'h78, 16'h0002);
      rd(8'h20, 16'h0000);
      rd(8'h7e, 16'h00c0);
      wr(8'h11, 16'h0000);
      repeat (4) @(negedge sys_clk);
      chk(16'(stores), 16'h0001);
      wr(8'hd4, 16'h00c8);
      rd(8'hd4, 16'h007f);
      wr(8'hd4, 16'h0000);
      wr(8'h38, 16'h8a00);
      wr(8'h39, 16'he004);
      wr(8'hd5, 16'hc010);
      repeat (250) @(negedge sys_clk);
      rd(8'h8c, 16'he01d);
      rd(8'h88, 16'hd900);
      @(negedge sys_clk) adc_samp.iout = 16'hff9c;
      repeat (250) @(negedge sys_clk);
      rd(8'h8c, 16'he000);
      for (int k = 0; k < 3; k++)
      begin
         s = (k == 0) ? 16'h04cd : (k == 1) ? 16'h03e8 : 16'h0514;
         @(negedge sys_clk) adc_samp.vout = s;
         repeat (250) @(negedge sys_clk);
         rd(8'h8b, s + (s >> 4));
         chk(output_good_flag_oe_b, k == 0);
      end
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h41, {8'h00, 2'(k), 6'h00});
         @(negedge sys_clk) fault_pins = 4'h1;
         repeat (8) @(negedge sys_clk);
         chk(conv_enable, k < 2);
         chk(output_good_flag_oe_b, 1'b0);
         repeat (8) @(negedge sys_clk) sw_tick = ~sw_tick;
         repeat (6) @(negedge sys_clk);
         chk(conv_enable, k == 0);
         fault_pins = 4'h0;
         repeat (8) @(negedge sys_clk);
         chk(conv_enable, k == 0 || k == 3);
         wr(8'h03, 16'h0000);
         repeat (8) @(negedge sys_clk);
         chk(conv_enable, 1'b1);
      end
      end_sim();
   end
endmodule
`default_nettype wire
